// File: hw/msc_ms_timer.v
/*
  Millisecond tick divider with a resettable millisecond counter.
  Assumes the 25 MHz system clock; the prescale is a parameter so simulation can shorten it.
*/
`timescale 1ns/100ps
module msc_ms_timer #(
  parameter MS_CYC = 25000
) (
  input wire clk,
  input wire resetn,
  input wire restart,
  output reg [13:0] ms_q
);
  reg [14:0] pre_q;

  // Restart clears both stages so a new window starts from zero; the count saturates.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 15'h0000;
      ms_q <= 14'h0000;
    end else if (restart) begin
      pre_q <= 15'h0000;
      ms_q <= 14'h0000;
    end else if (pre_q == MS_CYC - 1) begin
      pre_q <= 15'h0000;
      if (ms_q != 14'h3fff) ms_q <= ms_q + 14'h0001;
    end else begin
      pre_q <= pre_q + 15'h0001;
    end
  end
endmodule

// File: hw/msc_top.v
/*
  Mode supervision: sleep and standby control, fault clear, output kill, monitor routing,
  clock source selection and host watchdog, with Avalon-MM registers.
  Assumes pins are asynchronous to clk and measured speed values arrive synchronous to clk.
*/
`timescale 1ns/100ps
`include "msc_map.vh"

module msc_top #(
  parameter MS_CYC = `MSC_MS_CYC
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire speed_pin,
  input wire output_kill_pin,
  input wire tickle_pin,
  input wire ref_clock_pin,
  input wire [11:0] speed_analog,
  input wire [6:0] speed_duty_pct,
  input wire [15:0] speed_freq_hz,
  input wire [15:0] speed_digital,
  input wire latched_fault_in,
  input wire fault_cond_active,
  input wire [11:0] monitor_a_value,
  input wire [11:0] monitor_b_value,
  input wire [11:0] current_amp_output,
  output reg [11:0] monitor_a_source,
  output reg [11:0] monitor_b_source,
  output reg [11:0] monitor_out_a,
  output reg [11:0] monitor_out_b,
  output reg [11:0] shared_pin_out,
  output reg switches_hiz,
  output reg power_stage_on,
  output reg supplies_on,
  output reg bus_if_on,
  output reg motor_run,
  output reg ref_cal_on,
  output reg [7:0] ref_clock_rate,
  output reg clock_dither_on
);
  localparam ST_RUN = 2'd0;
  localparam ST_STBY = 2'd1;
  localparam ST_SLEEP = 2'd2;

  reg [31:0] ctrl_q, wdog_q, mon_q, clk_q;
  reg [1:0] st_q;
  reg flt_q, wd_flt_q, wd_lat_q, clr_q, tick_bus_q, wd_on_q;
  reg [2:0] spd_s_q, kill_s_q, tick_s_q, ref_s_q;
  reg spd_q, kill_q, tick_q, tick_prev_q;
  reg [15:0] ref_cnt_q;

  wire low_power_select = ctrl_q[`MSC_CTRL_LP];
  wire [1:0] speed_source = ctrl_q[`MSC_CTRL_SRC_LO +: 2];
  wire [1:0] profile_cfg = ctrl_q[`MSC_CTRL_PROF_LO +: 2];
  wire [6:0] input_hysteresis_pct = ctrl_q[`MSC_CTRL_HYS_LO +: 7];
  wire [15:0] input_max_freq = ctrl_q[`MSC_CTRL_FMAX_LO +: 16];
  wire host_watchdog_on = wdog_q[`MSC_WD_ON];
  wire watchdog_response = wdog_q[`MSC_WD_RESP];
  wire tickle_source = wdog_q[`MSC_WD_SRC];
  wire [1:0] watchdog_interval = wdog_q[`MSC_WD_INT_LO +: 2];

  // Three-stage pin synchronisers; speed, kill and tickle levels are accepted once stages two and three agree.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spd_s_q <= 3'h0;
      kill_s_q <= 3'h0;
      tick_s_q <= 3'h0;
      ref_s_q <= 3'h0;
      spd_q <= 1'b0;
      kill_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      spd_s_q <= {spd_s_q[1:0], speed_pin};
      kill_s_q <= {kill_s_q[1:0], output_kill_pin};
      tick_s_q <= {tick_s_q[1:0], tickle_pin};
      ref_s_q <= {ref_s_q[1:0], ref_clock_pin};
      if (spd_s_q[2] == spd_s_q[1]) spd_q <= spd_s_q[2];
      if (kill_s_q[2] == kill_s_q[1]) kill_q <= kill_s_q[2];
      if (tick_s_q[2] == tick_s_q[1]) tick_q <= tick_s_q[2];
    end
  end

  // Standby thresholds per speed source; analog, digital and frequency as 32-bit products compared without division.
  wire [6:0] duty_thr = (profile_cfg != 2'b00) ? 7'd0 :
    ((input_hysteresis_pct > `MSC_DUTY_MIN_PCT) ? input_hysteresis_pct : 7'd`MSC_DUTY_MIN_PCT);
  wire [31:0] ana_x100 = {20'h00000, speed_analog} * 32'd100;
  wire [31:0] dig_x100 = {16'h0000, speed_digital} * 32'd100;
  wire [31:0] dig_thr = {25'h0000000, duty_thr} * 32'd`MSC_DIG_FS;
  wire [31:0] frq_x100 = {16'h0000, speed_freq_hz} * 32'd100;
  wire [31:0] frq_raw = {25'h0000000, duty_thr} * {16'h0000, input_max_freq};
  wire [31:0] frq_min = 32'd`MSC_FREQ_MIN_HZ * 32'd100;
  wire [31:0] frq_thr = (frq_raw < frq_min) ? frq_min : frq_raw;
  reg below_en, above_ex;
  always @* begin
    case (speed_source)
      2'b00: begin
        below_en = ana_x100 < 32'd`MSC_ANA_EN_PCT * 32'd`MSC_ANA_FS;
        above_ex = ana_x100 > 32'd`MSC_ANA_EX_PCT * 32'd`MSC_ANA_FS;
      end
      2'b01: begin
        below_en = speed_duty_pct < duty_thr;
        above_ex = speed_duty_pct > duty_thr;
      end
      2'b10: begin
        below_en = dig_x100 < dig_thr;
        above_ex = dig_x100 > dig_thr;
      end
      default: begin
        below_en = frq_x100 < frq_thr;
        above_ex = frq_x100 > frq_thr;
      end
    endcase
  end

  // Sleep detection timer: runs while the pin stays low (and bus command zero), or high when asleep.
  wire [13:0] det_ms;
  wire sleep_cond = !spd_q && (speed_source != 2'b10 || speed_digital == 16'h0000);
  wire det_hold = (st_q == ST_SLEEP) ? spd_q : sleep_cond;
  wire [13:0] det_need = (speed_source == 2'b10) ? 14'd`MSC_SLEEP_ENTRY_MS : 14'd`MSC_SLEEP_DET_MS;
  msc_ms_timer #(.MS_CYC(MS_CYC)) u_det (
    .clk(clk),
    .resetn(resetn),
    .restart(!det_hold),
    .ms_q(det_ms)
  );

  // Mode state machine; sleep or standby chosen by the low-power select bit.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_RUN;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (low_power_select && det_hold && det_ms >= det_need) st_q <= ST_SLEEP;
          else if (!low_power_select && below_en) st_q <= ST_STBY;
        end
        ST_STBY: begin
          if (above_ex) st_q <= ST_RUN;
        end
        ST_SLEEP: begin
          if (det_hold && det_ms >= `MSC_SLEEP_DET_MS) st_q <= ST_RUN;
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // Watchdog: tickle from pin edge or bus bit, interval chosen by source and the two interval bits.
  wire tick_ev = tickle_source ? tick_bus_q : (tick_q && !tick_prev_q);
  reg [13:0] wd_lim;
  always @* begin
    case ({tickle_source, watchdog_interval})
      3'b000: wd_lim = 14'd100;
      3'b001: wd_lim = 14'd200;
      3'b010: wd_lim = 14'd500;
      3'b011: wd_lim = 14'd1000;
      3'b100: wd_lim = 14'd1000;
      3'b101: wd_lim = 14'd2000;
      3'b110: wd_lim = 14'd5000;
      default: wd_lim = 14'd10000;
    endcase
  end
  wire [13:0] wd_ms;
  wire wd_start = host_watchdog_on && !wd_on_q;
  wire wd_expire = host_watchdog_on && !wd_start && wd_ms >= wd_lim;
  // Expiry restarts the window too, so a timeout is a one-cycle event and a later fault clear can win.
  msc_ms_timer #(.MS_CYC(MS_CYC)) u_wd (
    .clk(clk),
    .resetn(resetn),
    .restart(!host_watchdog_on || wd_start || tick_ev || wd_expire),
    .ms_q(wd_ms)
  );

  // Fault flags; a new event in the cycle of a clear wins over the clear.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flt_q <= 1'b0;
      wd_flt_q <= 1'b0;
      wd_lat_q <= 1'b0;
      tick_prev_q <= 1'b0;
      wd_on_q <= 1'b0;
    end else begin
      tick_prev_q <= tick_q;
      wd_on_q <= host_watchdog_on;
      if (latched_fault_in) flt_q <= 1'b1;
      else if (clr_q && !fault_cond_active) flt_q <= 1'b0;
      if (wd_expire) begin
        wd_flt_q <= 1'b1;
        if (watchdog_response) wd_lat_q <= 1'b1;
      end else if (clr_q) begin
        wd_flt_q <= 1'b0;
        wd_lat_q <= 1'b0;
      end
    end
  end

  // Reference falling-edge counter, running while ref_cal_on is high and cleared when it drops, a simple calibration measure.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) ref_cnt_q <= 16'h0000;
    else if (!ref_cal_on) ref_cnt_q <= 16'h0000;
    else if (ref_s_q[2] && !ref_s_q[1]) ref_cnt_q <= ref_cnt_q + 16'h0001;
  end

  // Outputs, all registered.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switches_hiz <= 1'b1;
      power_stage_on <= 1'b0;
      supplies_on <= 1'b1;
      bus_if_on <= 1'b1;
      motor_run <= 1'b0;
      ref_cal_on <= 1'b0;
      ref_clock_rate <= 8'h00;
      clock_dither_on <= 1'b0;
      monitor_a_source <= 12'h000;
      monitor_b_source <= 12'h000;
      monitor_out_a <= 12'h000;
      monitor_out_b <= 12'h000;
      shared_pin_out <= 12'h000;
    end else begin
      switches_hiz <= kill_q || flt_q || wd_lat_q || st_q != ST_RUN;
      power_stage_on <= st_q != ST_SLEEP;
      supplies_on <= st_q != ST_SLEEP;
      bus_if_on <= st_q != ST_SLEEP;
      motor_run <= st_q == ST_RUN && !kill_q && !flt_q && !wd_lat_q;
      ref_cal_on <= clk_q[`MSC_CLK_SEL_LO +: 2] == 2'b11 && clk_q[`MSC_CLK_ON];
      ref_clock_rate <= clk_q[`MSC_CLK_RATE_LO +: 8];
      clock_dither_on <= !clk_q[`MSC_CLK_DITH];
      monitor_a_source <= mon_q[`MSC_MON_A_LO +: 12];
      monitor_b_source <= mon_q[`MSC_MON_B_LO +: 12];
      monitor_out_a <= mon_q[`MSC_MON_EN] ? monitor_a_value : 12'h000;
      monitor_out_b <= mon_q[`MSC_MON_EN] ? monitor_b_value : 12'h000;
      shared_pin_out <= (mon_q[`MSC_MON_SEL_LO +: 2] == 2'b00) ? monitor_b_value : current_amp_output;
    end
  end

  // Avalon slave: one wait cycle, answer on the second cycle of the request.
  // Reads load on the first cycle; writes land on the second, the edge where waitrequest is seen low.
  reg acc_q;
  wire [31:0] bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_q <= `MSC_CTRL_RST;
      wdog_q <= `MSC_WDOG_RST;
      mon_q <= `MSC_MON_RST;
      clk_q <= `MSC_CLK_RST;
      clr_q <= 1'b0;
      tick_bus_q <= 1'b0;
    end else begin
      clr_q <= 1'b0;
      tick_bus_q <= 1'b0;
      acc_q <= (avs_read || avs_write) && !acc_q;
      avs_waitrequest <= !((avs_read || avs_write) && !acc_q);
      if ((avs_write && acc_q) || (avs_read && !acc_q)) begin
        if (avs_write) begin
          if (avs_address == `MSC_REG_CTRL) ctrl_q <= (ctrl_q & ~bm) | (avs_writedata & bm);
          else if (avs_address == `MSC_REG_WDOG) wdog_q <= (wdog_q & ~bm) | (avs_writedata & bm);
          else if (avs_address == `MSC_REG_MON) mon_q <= (mon_q & ~bm) | (avs_writedata & bm);
          else if (avs_address == `MSC_REG_CLK) clk_q <= (clk_q & ~bm) | (avs_writedata & bm);
          else if (avs_address == `MSC_REG_CMD && avs_byteenable[0]) begin
            clr_q <= avs_writedata[`MSC_CMD_CLR];
            tick_bus_q <= avs_writedata[`MSC_CMD_TICK];
          end
        end else begin
          if (avs_address == `MSC_REG_CTRL) avs_readdata <= ctrl_q;
          else if (avs_address == `MSC_REG_WDOG) avs_readdata <= wdog_q;
          else if (avs_address == `MSC_REG_MON) avs_readdata <= mon_q;
          else if (avs_address == `MSC_REG_CLK) avs_readdata <= clk_q;
          else if (avs_address == `MSC_REG_SPEED)
            avs_readdata <= {14'h0000, below_en, above_ex, speed_digital};
          else if (avs_address == `MSC_REG_STATUS)
            avs_readdata <= {ref_cnt_q, 8'h00, kill_q, ref_cal_on, wd_lat_q, wd_flt_q, flt_q, 1'b0, st_q};
          else avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end
endmodule

// File: shared/msc_map.vh
/*
  Register offsets, field positions, reset values and timing counts for the mode supervision block.
  Assumes a 25 MHz clock and 32-bit Avalon-MM word addressing in bytes.
*/
`ifndef MSC_MAP_VH
`define MSC_MAP_VH
`define MSC_CLK_HZ 25000000
// Register byte offsets.
`define MSC_REG_CTRL 8'h00
`define MSC_REG_SPEED 8'h04
`define MSC_REG_WDOG 8'h08
`define MSC_REG_MON 8'h0c
`define MSC_REG_CLK 8'h10
`define MSC_REG_STATUS 8'h14
`define MSC_REG_CMD 8'h18
// CTRL fields.
`define MSC_CTRL_LP 0
`define MSC_CTRL_SRC_LO 1
`define MSC_CTRL_PROF_LO 3
`define MSC_CTRL_HYS_LO 8
`define MSC_CTRL_FMAX_LO 16
// WDOG fields.
`define MSC_WD_ON 0
`define MSC_WD_RESP 1
`define MSC_WD_SRC 2
`define MSC_WD_INT_LO 3
// MON fields.
`define MSC_MON_EN 0
`define MSC_MON_SEL_LO 1
`define MSC_MON_A_LO 8
`define MSC_MON_B_LO 20
// CLK fields.
`define MSC_CLK_SEL_LO 0
`define MSC_CLK_ON 2
`define MSC_CLK_DITH 3
`define MSC_CLK_RATE_LO 4
// CMD bits.
`define MSC_CMD_CLR 0
`define MSC_CMD_TICK 1
// Reset values.
`define MSC_CTRL_RST 32'h03e8_0100
`define MSC_WDOG_RST 32'h0000_0000
`define MSC_MON_RST 32'h0000_0000
`define MSC_CLK_RST 32'h0000_0000
// Thresholds: analog on 12-bit full scale, percent figures.
`define MSC_ANA_FS 4095
`define MSC_ANA_EN_PCT 1
`define MSC_ANA_EX_PCT 5
`define MSC_DUTY_MIN_PCT 1
`define MSC_DIG_FS 32767
`define MSC_FREQ_MIN_HZ 3
// Times.
`define MSC_MS_CYC (`MSC_CLK_HZ / 1000)
`define MSC_SLEEP_DET_MS 1
`define MSC_SLEEP_ENTRY_MS 1
`endif

// File: test/msc_host_model.sv
/*
  Host controller model for msc_top: it drives the tickle pin and the output kill pin.
  Assumes the bench asks for a tickle with a one-cycle request and for a kill with a level.
*/
`timescale 1ns/100ps
module msc_host_model #(
  parameter int HOLD = 64
) (
  input wire clk,
  input wire resetn,
  input wire tick_go,
  input wire kill_go,
  output logic tickle_pin,
  output logic output_kill_pin
);
  int tick_q;
  int kill_q;
  // A tickle is a high pulse of random width, so the device sees both prompt and slow edges.
  // The kill pin is held for HOLD cycles after the last request, because dropping it early is unsafe.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 0;
      kill_q <= 0;
      tickle_pin <= 1'b0;
      output_kill_pin <= 1'b0;
    end else begin
      tick_q <= tick_go ? 5 + $urandom % 6 : (tick_q > 0 ? tick_q - 1 : 0);
      kill_q <= kill_go ? HOLD : (kill_q > 0 ? kill_q - 1 : 0);
      tickle_pin <= tick_q > 0;
      output_kill_pin <= kill_go || kill_q > 0;
    end
  end
endmodule

// File: test/msc_top_checker.sv
/*
  Concurrent checks on the ports of msc_top, attached by the bind at the foot.
  Assumes one clock domain and the registered outputs described for the block.
*/
`timescale 1ns/100ps
module msc_top_checker (
  input wire clk,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire output_kill_pin,
  input wire [11:0] monitor_a_value,
  input wire [11:0] monitor_b_value,
  input wire [11:0] current_amp_output,
  input wire [11:0] monitor_out_a,
  input wire [11:0] monitor_out_b,
  input wire [11:0] shared_pin_out,
  input wire switches_hiz,
  input wire power_stage_on,
  input wire supplies_on,
  input wire bus_if_on,
  input wire motor_run,
  input wire ref_cal_on
);
  // All checks share the one clock and stay quiet while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  answer_bound_a: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  sleep_off_a: assert property (!bus_if_on |-> !supplies_on && !power_stage_on) else $error("sleep left on");
  sleep_run_a: assert property (!bus_if_on |-> !motor_run) else $error("motor runs asleep");
  kill_hiz_a: assert property (output_kill_pin [*8] |-> switches_hiz) else $error("kill ignored");
  mon_route_a: assert property ($past(resetn) |-> monitor_out_a == 12'h0 ||
    monitor_out_a == $past(monitor_a_value)) else $error("monitor a wrong");
  shared_route_a: assert property ($past(resetn) |-> shared_pin_out == $past(current_amp_output) ||
    shared_pin_out == $past(monitor_b_value)) else $error("shared pin wrong");
  boot_osc_a: assert property ($rose(resetn) |-> !ref_cal_on) else $error("boot not internal");
  mon_b_route_a: assert property ($past(resetn) |-> monitor_out_b == 12'h0 ||
    monitor_out_b == $past(monitor_b_value)) else $error("monitor b wrong");
  kill_stop_a: assert property (output_kill_pin [*8] |-> !motor_run) else $error("motor runs killed");
endmodule

bind msc_top msc_top_checker u_msc_top_checker (.*);

// File: test/test_msc_top.sv
/*
  Self-checking bench for msc_top: Avalon-MM tasks, a host model on the pins, and a watcher
  that compares each result with the oldest expectation in a queue.
  Assumes the millisecond prescale is shortened to 4 clock cycles.
*/
`timescale 1ns/100ps
`include "msc_map.vh"
module test_msc_top;
  logic clk = 0, resetn = 0, avs_read = 0, avs_write = 0, speed_pin = 1, ref_clock_pin = 0;
  logic latched_fault_in = 0, fault_cond_active = 0, tick_go = 0, kill_go = 0, ev = 0;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, v, got;
  logic [3:0] avs_byteenable = 4'hf;
  logic [11:0] speed_analog = 0, monitor_a_value = 0, monitor_b_value = 0, current_amp_output = 0;
  logic [6:0] speed_duty_pct = 0;
  logic [15:0] speed_freq_hz = 0, speed_digital = 0;
  wire [31:0] avs_readdata;
  wire [11:0] monitor_a_source, monitor_b_source, monitor_out_a, monitor_out_b, shared_pin_out;
  wire avs_waitrequest, tickle_pin, output_kill_pin, switches_hiz, power_stage_on, supplies_on;
  wire bus_if_on, motor_run, ref_cal_on, clock_dither_on;
  wire [7:0] ref_clock_rate;
  wire [31:0] outs = {monitor_a_source, ref_clock_rate, switches_hiz, power_stage_on, supplies_on,
    bus_if_on, ref_cal_on, clock_dither_on, monitor_b_source[5:0]};
  logic [63:0] q[$], e;
  int miscompares = 0, n_checks = 0, cyc = 0;
  int ent[4] = '{40, 2, 983, 29};
  int ext[4] = '{205, 4, 984, 31};

  msc_top #(.MS_CYC(4)) u_msc_top (.*);
  msc_host_model #(.HOLD(64)) u_msc_host_model (.*);

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic close_out;
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One bus transfer, held until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    q.push_back({m, x});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  // A snapshot of the pin outputs is compared in the cycle that ev is seen high.
  task automatic snap(input logic [31:0] m, input logic [31:0] x);
    @(posedge clk);
    q.push_back({m, x});
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
  endtask

  task automatic spd(input int s);
    speed_analog <= s[11:0];
    speed_duty_pct <= s[6:0];
    speed_freq_hz <= s[15:0];
    speed_digital <= s[15:0];
  endtask

  task automatic tick;
    tick_go <= 1'b1;
    wt(1);
    tick_go <= 1'b0;
  endtask

  // Watcher: only masked bits are compared, so fields the rules leave open never fail a run.
  always @(posedge clk) begin
    if ((avs_read && avs_waitrequest === 1'b0) || ev) begin
      e = q.pop_front();
      got = ev ? outs : avs_readdata;
      n_checks++;
      if (((got ^ e[31:0]) & e[63:32]) !== 32'h0) begin
        miscompares++;
        $display("ERROR %0t: got %h want %h", $time, got, e[31:0]);
      end
    end
  end

  // Free-running data inputs and a slow reference clock; a cycle ceiling cuts off hangs.
  always @(posedge clk) begin
    monitor_a_value <= $urandom;
    monitor_b_value <= $urandom;
    current_amp_output <= $urandom;
    ref_clock_pin <= ($urandom % 5 == 0) ? !ref_clock_pin : ref_clock_pin;
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    v = $urandom(64);
    wt(2);
    resetn <= 1'b1;
    rd(`MSC_REG_CTRL, 32'hffffffff, `MSC_CTRL_RST);
    foreach (ent[i]) rd(8'h08 + 8'(i * 4), 32'hffffffff, 32'(i == 3));
    rd(8'h1c, 32'hffffffff, 32'h0);
    v = $urandom;
    wr(`MSC_REG_MON, v);
    rd(`MSC_REG_MON, 32'hffffffff, v);
    bus(1'b1, `MSC_REG_MON, 32'h0, 4'h1);
    rd(`MSC_REG_MON, 32'hffffffff, v & 32'hffffff00);
    wr(`MSC_REG_MON, {v[31:8], 8'h01});
    snap(32'hfff0003f, {v[19:8], 14'h0, v[25:20]});
    wr(`MSC_REG_CLK, {20'h0, v[7:0], 4'h7});
    snap(32'h000ff0c0, {12'h0, v[7:0], 4'h0, 8'hc0});
    wr(`MSC_REG_CLK, {20'h0, v[7:0], 4'he});
    snap(32'h000000c0, 32'h0);
    // Standby per speed source, entered and left at values just past each threshold.
    for (int i = 0; i < 4; i++) begin
      wr(`MSC_REG_CTRL, 32'h03e80300 | 32'(i << 1));
      spd(ext[i]);
      wt(8);
      rd(`MSC_REG_STATUS, 32'h3, 32'h0);
      spd(ent[i]);
      wt(8);
      rd(`MSC_REG_STATUS, 32'h3, 32'h1);
      snap(32'h300, 32'h300);
      spd(ext[i]);
      wt(8);
      rd(`MSC_REG_STATUS, 32'h3, 32'h0);
    end
    wr(`MSC_REG_CTRL, 32'h03e80301);
    spd(0);
    speed_pin <= 1'b0;
    wt(2);
    speed_pin <= 1'b1;
    wt(20);
    snap(32'h700, 32'h700);
    speed_pin <= 1'b0;
    wt(40);
    snap(32'h700, 32'h0);
    speed_pin <= 1'b1;
    wt(40);
    snap(32'h300, 32'h300);
    wr(`MSC_REG_CTRL, 32'h03e80300);
    spd(205);
    fault_cond_active <= 1'b1;
    latched_fault_in <= 1'b1;
    wt(1);
    latched_fault_in <= 1'b0;
    wt(4);
    rd(`MSC_REG_STATUS, 32'h8, 32'h8);
    wr(`MSC_REG_CMD, 32'h1);
    rd(`MSC_REG_STATUS, 32'h8, 32'h8);
    fault_cond_active <= 1'b0;
    wt(2);
    wr(`MSC_REG_CMD, 32'h1);
    rd(`MSC_REG_STATUS, 32'h8, 32'h0);
    kill_go <= 1'b1;
    wt(10);
    snap(32'h800, 32'h800);
    rd(`MSC_REG_STATUS, 32'h80, 32'h80);
    kill_go <= 1'b0;
    wt(90);
    rd(`MSC_REG_STATUS, 32'h80, 32'h0);
    snap(32'h800, 32'h0);
    // Pin watchdog at 200 ms: ticks at 175 ms pass, where a 100 ms setting would have tripped.
    wr(`MSC_REG_WDOG, 32'hb);
    repeat (3) begin
      wt(700);
      tick();
    end
    rd(`MSC_REG_STATUS, 32'h30, 32'h0);
    wt(1000);
    rd(`MSC_REG_STATUS, 32'h30, 32'h30);
    snap(32'h800, 32'h800);
    wr(`MSC_REG_CMD, 32'h1);
    rd(`MSC_REG_STATUS, 32'h20, 32'h0);
    wr(`MSC_REG_WDOG, 32'h0);
    wr(`MSC_REG_WDOG, 32'h5);
    repeat (2) begin
      wt(3000);
      wr(`MSC_REG_CMD, 32'h2);
    end
    rd(`MSC_REG_STATUS, 32'h10, 32'h0);
    wt(5000);
    rd(`MSC_REG_STATUS, 32'h30, 32'h10);
    wt(4);
    close_out();
  end
endmodule
